// file: inc/stamp_pkg.sv
// Purpose: Shared constants and types for the dual-port frame timestamp unit.
// Assumes: 50 MHz core clock, byte-wide register port.
// Notes:   Offsets are byte addresses on the register port.
package stamp_pkg;

  localparam int NUM_PORTS     = 2;
  localparam int STAMP_W       = 16;

  // Clock and timestamp resolutions.
  localparam int CLK_PERIOD_NS = 20;
  localparam int RES0_NS       = 40;
  localparam int RES1_NS       = 80;
  localparam int RES2_NS       = 160;
  localparam int RES3_NS       = 1000;
  localparam logic [7:0] RES0_CYC = 8'(RES0_NS / CLK_PERIOD_NS);
  localparam logic [7:0] RES1_CYC = 8'(RES1_NS / CLK_PERIOD_NS);
  localparam logic [7:0] RES2_CYC = 8'(RES2_NS / CLK_PERIOD_NS);
  localparam logic [7:0] RES3_CYC = 8'(RES3_NS / CLK_PERIOD_NS);

  // Register offsets.
  localparam logic [7:0] ADDR_COUNT_CONFIG   = 8'h25;
  localparam logic [7:0] ADDR_STAMP_CONTROL  = 8'h26;
  localparam logic [7:0] ADDR_LINE_UPPER     = 8'h27;
  localparam logic [7:0] ADDR_LINE_LOWER     = 8'h28;
  localparam logic [7:0] ADDR_STAMP_STATE    = 8'h29;
  localparam logic [7:0] ADDR_P0_STAMP_UPPER = 8'h2A;
  localparam logic [7:0] ADDR_P0_STAMP_LOWER = 8'h2B;
  localparam logic [7:0] ADDR_P1_STAMP_UPPER = 8'h2C;
  localparam logic [7:0] ADDR_P1_STAMP_LOWER = 8'h2D;

  // Field positions.
  localparam int CTL_HOLD_BIT    = 4;
  localparam int CTL_EN0_BIT     = 0;
  localparam int CTL_EN1_BIT     = 1;
  localparam int CFG_EDGE_BIT    = 6;
  localparam int CFG_RES_LSB     = 4;
  localparam int CFG_FREERUN_BIT = 1;
  localparam int CFG_TRIG_BIT    = 0;
  localparam int STS_READY_BIT   = 4;
  localparam int STS_VALID_LSB   = 0;

  // Values after reset.
  localparam logic [7:0]         RST_BYTE  = 8'h00;
  localparam logic [STAMP_W-1:0] RST_STAMP = 16'h0000;

  typedef struct packed {
    logic       sync_edge_select;
    logic [1:0] count_resolution;
    logic       unsynced_counting;
    logic       trigger_select;
  } count_config_t;

  typedef struct packed {
    logic       line_start;
    logic       frame_start;
  } port_events_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef enum logic [0:0] {ARM_IDLE, ARM_WAIT_FRAME} arm_state_t;

endpackage

// file: core/stamp_tick_gen.sv
// Purpose: Produces the one-cycle count enable at the selected resolution.
// Assumes: Single 50 MHz clock, synchronous active-high reset.
// Notes:   A restart realigns the tick phase to the frame sync edge.
`timescale 1ns/1ps
module stamp_tick_gen
  import stamp_pkg::*;
(
  input  wire logic       clk_i,     // Core clock
  input  wire logic       rst_i,     // Synchronous reset
  input  wire logic [1:0] sel_i,     // Resolution select
  input  wire logic       restart_i, // Restart the period
  output logic            tick_o     // One-cycle count enable
);

  logic [7:0] div_ff;
  logic [7:0] nxt_div;
  logic       tick_ff;
  logic       nxt_tick;
  logic [7:0] period;

  always_comb
  begin
    case (sel_i)
      2'h0:    period = RES0_CYC;
      2'h1:    period = RES1_CYC;
      2'h2:    period = RES2_CYC;
      default: period = RES3_CYC;
    endcase
    nxt_tick = 1'b0;
    nxt_div  = div_ff + 8'h01;
    if (restart_i)
      nxt_div = 8'h00;
    else if (div_ff >= period - 8'h01)
    begin
      nxt_div  = 8'h00;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_ff  <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule

// file: core/frame_timestamp.sv
// Purpose: Captures a 16-bit timestamp per receive port at line or frame start.
// Assumes: Port events are one-cycle pulses synchronous to clk_i.
// Notes:   Read data appear in the cycle after the read strobe only.
`timescale 1ns/1ps
// Behaviour
// - Freeze holds stamps and clears ready
// - Capture only on ports whose enable is set
// - Line mode captures at programmed 16-bit line
// - Free-run frame mode arms at programmed line
// - Ready flag at status bit four
// - Per-port valid flags at status bits 0,1
// - Stamps readable as upper and lower bytes
// - Mode bit selects line or frame trigger
// - Run bit selects sync-referenced or free counting
// - Polarity bit selects active sync edge
module frame_timestamp
  import stamp_pkg::*;
(
  input  wire logic                          clk_i,     // Core clock, 50 MHz
  input  wire logic                          rst_i,     // Synchronous reset
  input  wire reg_req_t                      req_i,     // Register request
  output logic [7:0]                         rdata_o,   // Read data, cycle after read
  input  wire port_events_t [NUM_PORTS-1:0]  events_i,  // Line and frame start per port
  input  wire logic                          fsync_i    // Frame sync level
);

  function automatic logic [7:0] stamp_byte(input logic [STAMP_W-1:0] v, input logic upper);
    stamp_byte = upper ? v[15:8] : v[7:0];
  endfunction

  // The first line after a frame start is line one.
  function automatic logic line_hit(input logic [STAMP_W-1:0] cnt, input logic [STAMP_W-1:0] target);
    line_hit = (cnt + 16'h0001) == target;
  endfunction

  // Register state.
  count_config_t           cfg_ff;
  count_config_t           nxt_cfg;
  logic                    hold_captures_ff;
  logic                    nxt_hold_captures;
  logic [NUM_PORTS-1:0]    capture_on_ff;
  logic [NUM_PORTS-1:0]    nxt_capture_on;
  logic [7:0]              trigger_line_upper_ff;
  logic [7:0]              nxt_trigger_line_upper;
  logic [7:0]              trigger_line_lower_ff;
  logic [7:0]              nxt_trigger_line_lower;
  logic [7:0]              rdata_ff;
  logic [7:0]              nxt_rdata;
  logic [STAMP_W-1:0]      trigger_line_number;

  // Capture state.
  logic [STAMP_W-1:0]      count_ff;
  logic [STAMP_W-1:0]      nxt_count;
  logic                    fsync_prev_ff;
  logic                    nxt_fsync_prev;
  logic [STAMP_W-1:0]      line_cnt_ff   [NUM_PORTS];
  logic [STAMP_W-1:0]      nxt_line_cnt  [NUM_PORTS];
  logic [STAMP_W-1:0]      stamp_ff      [NUM_PORTS];
  logic [STAMP_W-1:0]      nxt_stamp     [NUM_PORTS];
  arm_state_t              arm_ff        [NUM_PORTS];
  arm_state_t              nxt_arm       [NUM_PORTS];
  logic [NUM_PORTS-1:0]    capture_valid_ff;
  logic [NUM_PORTS-1:0]    nxt_capture_valid;
  logic                    captures_readable_ff;
  logic                    nxt_captures_readable;
  logic [NUM_PORTS-1:0]    capture_now;
  logic                    sync_edge;
  logic                    tick;
  logic                    resume;
  logic [NUM_PORTS-1:0]    frame_seen;
  logic [NUM_PORTS-1:0]    line_seen;
  logic [NUM_PORTS-1:0]    line_reached;
  logic                    count_restart;
  logic                    all_enabled_valid;

  assign trigger_line_number = {trigger_line_upper_ff, trigger_line_lower_ff};

  // Register writes.
  always_comb
  begin
    nxt_cfg                = cfg_ff;
    nxt_hold_captures      = hold_captures_ff;
    nxt_capture_on         = capture_on_ff;
    nxt_trigger_line_upper = trigger_line_upper_ff;
    nxt_trigger_line_lower = trigger_line_lower_ff;
    if (req_i.wr)
    begin
      case (req_i.addr)
        ADDR_COUNT_CONFIG:
        begin
          nxt_cfg.sync_edge_select  = req_i.wdata[CFG_EDGE_BIT];
          nxt_cfg.count_resolution  = req_i.wdata[CFG_RES_LSB +: 2];
          nxt_cfg.unsynced_counting = req_i.wdata[CFG_FREERUN_BIT];
          nxt_cfg.trigger_select    = req_i.wdata[CFG_TRIG_BIT];
        end
        ADDR_STAMP_CONTROL:
        begin
          nxt_hold_captures = req_i.wdata[CTL_HOLD_BIT];
          nxt_capture_on    = {req_i.wdata[CTL_EN1_BIT], req_i.wdata[CTL_EN0_BIT]};
        end
        // The two halves land on separate writes, so a capture between them sees a mixed line number.
        ADDR_LINE_UPPER:
        begin
          nxt_trigger_line_upper = req_i.wdata;
        end
        ADDR_LINE_LOWER:
        begin
          nxt_trigger_line_lower = req_i.wdata;
        end
        default:
        begin
          nxt_cfg = cfg_ff;
        end
      endcase
    end
  end

  // Register reads; unmapped and reserved locations read as zero.
  always_comb
  begin
    nxt_rdata = RST_BYTE;
    if (req_i.rd)
    begin
      case (req_i.addr)
        ADDR_COUNT_CONFIG:
        begin
          nxt_rdata[CFG_EDGE_BIT]        = cfg_ff.sync_edge_select;
          nxt_rdata[CFG_RES_LSB +: 2]    = cfg_ff.count_resolution;
          nxt_rdata[CFG_FREERUN_BIT]     = cfg_ff.unsynced_counting;
          nxt_rdata[CFG_TRIG_BIT]        = cfg_ff.trigger_select;
        end
        ADDR_STAMP_CONTROL:
        begin
          nxt_rdata[CTL_HOLD_BIT]        = hold_captures_ff;
          nxt_rdata[CTL_EN1_BIT]         = capture_on_ff[1];
          nxt_rdata[CTL_EN0_BIT]         = capture_on_ff[0];
        end
        ADDR_LINE_UPPER:     nxt_rdata = trigger_line_upper_ff;
        ADDR_LINE_LOWER:     nxt_rdata = trigger_line_lower_ff;
        ADDR_STAMP_STATE:
        begin
          nxt_rdata[STS_READY_BIT]       = captures_readable_ff;
          nxt_rdata[STS_VALID_LSB +: 2]  = capture_valid_ff;
        end
        ADDR_P0_STAMP_UPPER: nxt_rdata = stamp_byte(stamp_ff[0], 1'b1);
        ADDR_P0_STAMP_LOWER: nxt_rdata = stamp_byte(stamp_ff[0], 1'b0);
        ADDR_P1_STAMP_UPPER: nxt_rdata = stamp_byte(stamp_ff[1], 1'b1);
        ADDR_P1_STAMP_LOWER: nxt_rdata = stamp_byte(stamp_ff[1], 1'b0);
        default:             nxt_rdata = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_ff                <= '0;
      hold_captures_ff      <= 1'b0;
      capture_on_ff         <= '0;
      trigger_line_upper_ff <= RST_BYTE;
      trigger_line_lower_ff <= RST_BYTE;
      rdata_ff              <= RST_BYTE;
    end
    else
    begin
      cfg_ff                <= nxt_cfg;
      hold_captures_ff      <= nxt_hold_captures;
      capture_on_ff         <= nxt_capture_on;
      trigger_line_upper_ff <= nxt_trigger_line_upper;
      trigger_line_lower_ff <= nxt_trigger_line_lower;
      rdata_ff              <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

  // Active frame sync edge; the pin is already synchronous to clk_i.
  assign sync_edge = cfg_ff.sync_edge_select ? (fsync_prev_ff & ~fsync_i)
                                             : (~fsync_prev_ff & fsync_i);

  // Sync-referenced counting restarts both the divider and the count, so stamps measure
  // time from the active sync edge; free-run counting ignores the pin altogether.
  assign count_restart = sync_edge & ~cfg_ff.unsynced_counting;

  // Realigning the divider makes the first count one cycle longer but keeps every later count the same length.
  stamp_tick_gen u_tick
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .sel_i     (cfg_ff.count_resolution),
    .restart_i (count_restart),
    .tick_o    (tick)
  );

  // Timestamp counter; in sync-referenced mode it restarts at the active edge.
  always_comb
  begin
    nxt_fsync_prev = fsync_i;
    nxt_count      = count_ff;
    if (count_restart)
      nxt_count = RST_STAMP;
    else if (tick)
      nxt_count = count_ff + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_ff      <= RST_STAMP;
      fsync_prev_ff <= 1'b0;
    end
    else
    begin
      count_ff      <= nxt_count;
      fsync_prev_ff <= nxt_fsync_prev;
    end
  end

  // A resume is the write that drops the freeze; it opens a new capture round.
  // Clearing the flags at resume keeps a stale stamp from counting toward the next ready.
  assign resume = hold_captures_ff & ~nxt_hold_captures;

  // Event decode per port; the line hit looks at the count before this line's increment.
  always_comb
  begin
    frame_seen   = '0;
    line_seen    = '0;
    line_reached = '0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      frame_seen[p]   = events_i[p].frame_start;
      line_seen[p]    = events_i[p].line_start;
      line_reached[p] = line_seen[p] && line_hit(line_cnt_ff[p], trigger_line_number);
    end
  end

  // Per-port line counting, trigger decision and capture.
  always_comb
  begin
    nxt_capture_valid = capture_valid_ff;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      nxt_line_cnt[p] = line_cnt_ff[p];
      nxt_arm[p]      = arm_ff[p];
      nxt_stamp[p]    = stamp_ff[p];
      capture_now[p]  = 1'b0;
      if (frame_seen[p])
        nxt_line_cnt[p] = RST_STAMP;
      else if (line_seen[p])
        nxt_line_cnt[p] = line_cnt_ff[p] + 16'h0001;
      if (!cfg_ff.trigger_select)
      begin
        nxt_arm[p]     = ARM_IDLE;
        capture_now[p] = line_reached[p];
      end
      else if (!cfg_ff.unsynced_counting)
      begin
        nxt_arm[p]     = ARM_IDLE;
        capture_now[p] = frame_seen[p];
      end
      else
      begin
        case (arm_ff[p])
          ARM_IDLE:
          begin
            if (line_reached[p])
              nxt_arm[p] = ARM_WAIT_FRAME;
          end
          // A frame start seen before the line hit is ignored, so the capture always follows the line.
          ARM_WAIT_FRAME:
          begin
            if (frame_seen[p])
            begin
              capture_now[p] = 1'b1;
              nxt_arm[p]     = ARM_IDLE;
            end
          end
          default: nxt_arm[p] = ARM_IDLE;
        endcase
      end
      // Disabled ports and a frozen unit store nothing.
      capture_now[p] = capture_now[p] & capture_on_ff[p] & ~hold_captures_ff;
      if (resume)
        nxt_capture_valid[p] = 1'b0;
      if (capture_now[p])
      begin
        nxt_stamp[p]         = count_ff;
        nxt_capture_valid[p] = 1'b1;
      end
    end
  end

  // With no port enabled there is nothing to wait for, so ready never sets.
  assign all_enabled_valid = (capture_on_ff != '0) && ((nxt_capture_valid & capture_on_ff) == capture_on_ff);

  // Ready needs every enabled port captured; freeze forces it low.
  always_comb
  begin
    nxt_captures_readable = captures_readable_ff;
    if (nxt_hold_captures)
      nxt_captures_readable = 1'b0;
    else if (all_enabled_valid)
      nxt_captures_readable = 1'b1;
    else if (resume)
      nxt_captures_readable = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      capture_valid_ff     <= '0;
      captures_readable_ff <= 1'b0;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        line_cnt_ff[p] <= RST_STAMP;
        stamp_ff[p]    <= RST_STAMP;
        arm_ff[p]      <= ARM_IDLE;
      end
    end
    else
    begin
      capture_valid_ff     <= nxt_capture_valid;
      captures_readable_ff <= nxt_captures_readable;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        line_cnt_ff[p] <= nxt_line_cnt[p];
        stamp_ff[p]    <= nxt_stamp[p];
        arm_ff[p]      <= nxt_arm[p];
      end
    end
  end

endmodule

// file: sim/stamp_chk.sv
// Purpose: Register-port checks for the frame timestamp unit.
// Assumes: Shadows follow only the writes taken on req_i.
// Notes:   Stamp values are judged by the bench.
`timescale 1ns/1ps
module stamp_chk
  import stamp_pkg::*;
(
  input wire logic                         clk_i,    // Core clock
  input wire logic                         rst_i,    // Synchronous reset
  input wire reg_req_t                     req_i,    // Register request
  input wire logic [7:0]                   rdata_o,  // Read data
  input wire port_events_t [NUM_PORTS-1:0] events_i, // Port events
  input wire logic                         fsync_i   // Frame sync
);
  logic [7:0] cfg_ff;
  logic [7:0] ctl_ff;
  logic [7:0] hi_ff;
  logic [7:0] lo_ff;
  logic       sts_rd;

  assign sts_rd = req_i.rd && req_i.addr == ADDR_STAMP_STATE;

  // Reserved bits are masked here so the readback checks also cover them.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      {cfg_ff, ctl_ff, hi_ff, lo_ff} <= '0;
    else if (req_i.wr)
      case (req_i.addr)
        ADDR_COUNT_CONFIG:  cfg_ff <= req_i.wdata & 8'h73;
        ADDR_STAMP_CONTROL: ctl_ff <= req_i.wdata & 8'h13;
        ADDR_LINE_UPPER:    hi_ff <= req_i.wdata;
        ADDR_LINE_LOWER:    lo_ff <= req_i.wdata;
        default:            ;
      endcase
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_read_idle_zero: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
    else $error("Read data seen without a read");
  a_cfg_readback: assert property (req_i.rd && req_i.addr == ADDR_COUNT_CONFIG |=> rdata_o == $past(cfg_ff))
    else $error("Config readback wrong");
  a_ctl_readback: assert property (req_i.rd && req_i.addr == ADDR_STAMP_CONTROL |=> rdata_o == $past(ctl_ff))
    else $error("Control readback wrong");
  a_line_upper: assert property (req_i.rd && req_i.addr == ADDR_LINE_UPPER |=> rdata_o == $past(hi_ff))
    else $error("Line upper readback wrong");
  a_line_lower: assert property (req_i.rd && req_i.addr == ADDR_LINE_LOWER |=> rdata_o == $past(lo_ff))
    else $error("Line lower readback wrong");
  a_status_reserved: assert property (sts_rd |=> (rdata_o & 8'hEC) == 8'h00)
    else $error("Status reserved bits set");
  a_freeze_no_ready: assert property (sts_rd && ctl_ff[CTL_HOLD_BIT] |=> !rdata_o[STS_READY_BIT])
    else $error("Ready seen while frozen");
  a_ready_all_valid: assert property ($past(sts_rd) && rdata_o[STS_READY_BIT] |->
    $past(ctl_ff[1:0]) != 2'b00 && (rdata_o[1:0] & $past(ctl_ff[1:0])) == $past(ctl_ff[1:0]))
    else $error("Ready before all enabled ports valid");
  a_unmapped_zero: assert property (req_i.rd && (req_i.addr < ADDR_COUNT_CONFIG ||
    req_i.addr > ADDR_P1_STAMP_LOWER) |=> rdata_o == 8'h00)
    else $error("Unmapped read not zero");

  c_ready_seen: cover property ($past(sts_rd) && rdata_o[STS_READY_BIT]);
  c_frozen_read: cover property (sts_rd && ctl_ff[CTL_HOLD_BIT]);
  c_sync_rise: cover property ($rose(fsync_i));
endmodule

bind frame_timestamp stamp_chk chk (
  .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .events_i(events_i), .fsync_i(fsync_i));

// file: sim/video_timing_model.sv
// Purpose: Receive-port video timing source for both ports.
// Assumes: Called from the bench right after a rising edge.
// Notes:   Port 1 repeats port 0 a fixed skew later.
`timescale 1ns/1ps
module video_timing_model
  import stamp_pkg::*;
(
  input  wire logic                    clk_i,    // Core clock
  output port_events_t [NUM_PORTS-1:0] events_o, // Per-port events
  output logic                         fsync_o   // Frame sync level
);
  localparam int SKEW = 16;
  port_events_t            ev0 = '0;
  port_events_t [SKEW-1:0] dly = '0;

  initial fsync_o = 1'b0;
  always @(posedge clk_i) dly <= {dly[SKEW-2:0], ev0};
  // The skew makes the two ports' stamps differ by a known count.
  assign events_o = {dly[SKEW-1], ev0};

  // Sync rises one cycle before frame start, so a capture never races the counter restart.
  task automatic frame(input int lines, input int per);
    fsync_o <= 1'b1;
    for (int c = 1; c <= lines * per + SKEW + 4; c++)
    begin
      @(posedge clk_i);
      ev0 <= '{line_start: c % per == 0 && c <= lines * per, frame_start: c == 1};
      fsync_o <= c < 20;
    end
  endtask
endmodule

// file: sim/tb.sv
// Purpose: Self-checking bench for the dual-port frame timestamp unit.
// Assumes: Read results are noted at issue and compared a cycle later.
// Notes:   Stamps allow two counts, as the expected values only estimate the delay from sync edge to capture.
`timescale 1ns/1ps
module tb
  import stamp_pkg::*;
;
  typedef struct {logic [7:0] v; int tol;} exp_t;
  logic                         clk_i = 1'b0;
  logic                         rst_i = 1'b1;
  reg_req_t                     req = '0;
  logic [7:0]                   rdata;
  port_events_t [NUM_PORTS-1:0] ev;
  logic                         fs;
  logic                         rd_d1 = 1'b0;
  exp_t                         q[$];
  int                           fail_count = 0;
  int                           total_checks = 0;
  logic [31:0]                  rnd = 32'h9EB16DAC;
  logic [7:0]                   m[6];
  logic [7:0]                   msk[6] = '{8'h73, 8'h13, 8'hFF, 8'hFF, 8'h00, 8'h00};
  int                           ns[4] = '{40, 80, 160, 1000};
  int                           rc;
  int                           e0;

  always #10 clk_i = ~clk_i;

  frame_timestamp dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata), .events_i(ev), .fsync_i(fs));
  video_timing_model mdl (.clk_i(clk_i), .events_o(ev), .fsync_o(fs));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input int tol = 0);
    q.push_back('{e, tol});
    bus(a, 8'h00, 1'b0);
  endtask

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic check(input logic [7:0] seen, input exp_t x);
    total_checks++;
    if (seen !== x.v && (x.tol == 0 || $isunknown(seen) || seen + x.tol < x.v || seen > x.v + x.tol))
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, x.v);
    end
  endtask

  task automatic final_report;
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    if (rd_d1)
      check(rdata, q.pop_front());
    rd_d1 <= req.rd;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    final_report();
  end

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 8'h24; a <= 8'h2E; a++)
      rd(8'(a), 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      m[i] = rnd[7:0];
      wr(8'(8'h25 + i), m[i]);
    end
    for (int i = 0; i < 6; i++)
      rd(8'(8'h25 + i), m[i] & msk[i]);
    for (int r = 0; r < 4; r++)
    begin
      rc = ns[r] / 20;
      e0 = (192 - 20 * r[0]) / rc;
      wr(ADDR_COUNT_CONFIG, 8'({1'b0, r[0], r[1:0], 4'h0}));
      wr(ADDR_LINE_UPPER, 8'h00);
      wr(ADDR_LINE_LOWER, 8'h0C);
      wr(ADDR_STAMP_CONTROL, 8'h13);
      wr(ADDR_STAMP_CONTROL, 8'h03);
      rd(ADDR_STAMP_STATE, 8'h00);
      fork
        mdl.frame(12, 16);
        begin
          idle(200);
          rd(ADDR_STAMP_STATE, 8'h01);
          idle(1);
        end
      join
      rd(ADDR_STAMP_STATE, 8'h13);
      wr(ADDR_STAMP_CONTROL, 8'h13);
      // The second pass follows a shorter frame, so unheld stamps would differ.
      for (int k = 0; k < 2; k++)
      begin
        rd(ADDR_STAMP_STATE, 8'h03);
        rd(ADDR_P0_STAMP_UPPER, 8'h00);
        rd(ADDR_P0_STAMP_LOWER, 8'(e0), 2);
        rd(ADDR_P1_STAMP_UPPER, 8'h00);
        rd(ADDR_P1_STAMP_LOWER, 8'(e0 + 16 / rc), 2);
        idle(2);
        if (k == 0)
          mdl.frame(12, 4);
      end
    end
    wr(ADDR_COUNT_CONFIG, 8'h03);
    wr(ADDR_LINE_LOWER, 8'h03);
    wr(ADDR_STAMP_CONTROL, 8'h01);
    idle(1);
    mdl.frame(2, 16);
    rd(ADDR_STAMP_STATE, 8'h00);
    idle(1);
    mdl.frame(5, 16);
    rd(ADDR_STAMP_STATE, 8'h00);
    idle(1);
    mdl.frame(1, 16);
    rd(ADDR_STAMP_STATE, 8'h11);
    wr(ADDR_COUNT_CONFIG, 8'h01);
    wr(ADDR_STAMP_CONTROL, 8'h13);
    wr(ADDR_STAMP_CONTROL, 8'h03);
    idle(1);
    mdl.frame(1, 16);
    rd(ADDR_STAMP_STATE, 8'h13);
    rd(ADDR_P0_STAMP_LOWER, 8'h00, 2);
    rd(ADDR_P1_STAMP_LOWER, 8'h08, 2);
    idle(4);
    final_report();
  end
endmodule
